// *** logic/ext_irq_pkg.sv ***
`default_nettype none
package ext_irq_pkg;
  localparam int NUM_EXT = 8;
  localparam int NUM_LINES = 9;
  localparam int NMI_BIT = 8;
  localparam int SCAN_PINS = 8;
  localparam int IDX_W = 3;
  localparam int SCAN_PRESCALE_W = 5;
  localparam int STEP_W = 33;
  localparam int CLK_HZ = 250_000_000;
  localparam int LF_CLK_HZ = 32_000;
  localparam int LF_DIV_CYCLES = CLK_HZ / LF_CLK_HZ;
  localparam int RC_CLK_HZ_DEFAULT = 100_000;
  localparam logic [NUM_LINES-1:0] LINE_RST = 9'h000;
  localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
  localparam logic [STEP_W-1:0] STEP_ONE = 33'h0_0000_0001;
endpackage : ext_irq_pkg
`default_nettype wire

// *** logic/tick_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 2
) (
  input wire logic ref_clk,
  input wire logic rstn,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    tick_next = (cnt_reg == LAST);
    cnt_next = tick_next ? '0 : cnt_reg + CW'(1);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : tick_divider
`default_nettype wire

// *** logic/line_detect.sv ***
`timescale 1ns/100ps
`default_nettype none
module line_detect (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic pin_sync,
  input wire logic sample_en,
  input wire logic line_active,
  input wire logic sense_level,
  input wire logic edge_rise,
  input wire logic level_high,
  input wire logic filter_on,
  input wire logic async_on,
  output logic trig
);
  logic cand_reg;
  logic cand_next;
  logic val_reg;
  logic val_next;
  logic prev_reg;
  logic prev_next;
  logic use_filt;
  logic level_eff;
  logic pol;

  always_comb begin
    use_filt = filter_on & ~async_on; // RL8
    level_eff = sense_level | async_on; // RL4 RL8
    pol = sense_level ? level_high : edge_rise; // RL5 RL6
    cand_next = cand_reg;
    val_next = val_reg;
    prev_next = val_reg;
    if (sample_en) begin
      cand_next = pin_sync;
      // Filtered value moves only after two equal samples
      val_next = (use_filt && pin_sync != cand_reg) ? val_reg : pin_sync; // RL7
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // Pulled-up pin idles high; a low reset value would fake an edge
      cand_reg <= 1'b1;
      val_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      cand_reg <= cand_next;
      val_reg <= val_next;
      prev_reg <= prev_next;
    end
  end

  assign trig = line_active & (level_eff ? (val_reg == pol) : (val_reg != prev_reg && val_reg == pol)); // RL4
endmodule : line_detect
`default_nettype wire

// *** logic/ext_irq_unit.sv ***
// Overview of operation
// RL1 - Line enable/disable strobes set or clear enables; enabled state is readable.
// RL2 - Irq enable/disable strobes unmask or mask lines; mask state is readable.
// RL3 - Trigger sets status flag; it stays until the clear strobe bit.
// RL4 - Sense-type bit: zero edge detection, one level detection.
// RL5 - Edge lines: polarity zero falling, one rising.
// RL6 - Level lines: polarity zero low level, one high level.
// RL7 - Per-line spike filter enabled by its filter bit.
// RL8 - Asynchronous lines: edge treated as level, filter disabled.
// RL9 - Normally pins sampled on the core clock; shorter pulses may be missed.
// RL10 - In stop mode synchronous lines sampled by the low-frequency tick.
// RL11 - In static mode only asynchronous lines stay active and wake.
// RL12 - Trigger wakes the part; unmasked lines go to handler, else resume.
// RL13 - Non-maskable line has all features and drives the NMI request.
// RL14 - All lines disabled after reset.
// RL15 - Scan enable starts scanning with only output zero driven low.
// RL16 - Low position advances every 2^(prescale+1) RC cycles, wrapping.
// RL17 - Scanning halts while any request is active; index stays readable.
// RL18 - Software wires rows to pulled-up pins with low or falling sense.
// RL19 - Each pin has its own independently maskable request.
// RL20 - Three-bit read-only index of the driven-low scan output.
// RL21 - Five-bit prescale selects the scan step period.
// RL22 - Request asserted while flag and mask are both set, NMI likewise.
// RL23 - Synchronous lines pass a two-stage synchroniser before detection.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_unit #(
  parameter int LF_DIV = ext_irq_pkg::LF_DIV_CYCLES,
  parameter int RC_DIV = ext_irq_pkg::CLK_HZ / ext_irq_pkg::RC_CLK_HZ_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] ext_irq_pin_n,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] line_enable_strobe,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] line_disable_strobe,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] irq_enable_strobe,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] irq_disable_strobe,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] irq_clear_strobe,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] sense_type,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] edge_polarity,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] level_polarity,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] filter_enable,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] async_select,
  input wire logic test_enable,
  input wire logic [ext_irq_pkg::NUM_LINES-1:0] test_trigger,
  input wire logic stop_mode,
  input wire logic static_mode,
  input wire logic scan_enable,
  input wire logic [ext_irq_pkg::SCAN_PRESCALE_W-1:0] scan_prescale,
  output logic [ext_irq_pkg::NUM_LINES-1:0] line_enabled,
  output logic [ext_irq_pkg::NUM_LINES-1:0] irq_mask_view,
  output logic [ext_irq_pkg::NUM_LINES-1:0] irq_status_flags,
  output logic [ext_irq_pkg::NUM_EXT-1:0] irq_req,
  output logic nmi_req,
  output logic wake,
  output logic wake_to_handler,
  output logic [ext_irq_pkg::SCAN_PINS-1:0] scan_out,
  output logic [ext_irq_pkg::SCAN_PINS-1:0] scan_oe,
  output logic [ext_irq_pkg::IDX_W-1:0] scan_index
);
  import ext_irq_pkg::*;

  logic [NUM_LINES-1:0] sync1_reg;
  logic [NUM_LINES-1:0] sync2_reg;
  logic lf_tick;
  logic rc_tick;
  logic [NUM_LINES-1:0] det_vec;
  logic [NUM_LINES-1:0] trig_vec;
  logic [NUM_LINES-1:0] en_set;

  logic [NUM_LINES-1:0] enabled_reg;
  logic [NUM_LINES-1:0] enabled_next;
  logic [NUM_LINES-1:0] mask_reg;
  logic [NUM_LINES-1:0] mask_next;
  logic [NUM_LINES-1:0] flags_reg;
  logic [NUM_LINES-1:0] flags_next;
  logic [NUM_EXT-1:0] req_reg;
  logic [NUM_EXT-1:0] req_next;
  logic nmi_reg;
  logic nmi_next;
  logic wake_reg;
  logic wake_next;
  logic wake_h_reg;
  logic wake_h_next;
  logic req_any;

  logic [STEP_W-1:0] step_cnt_reg;
  logic [STEP_W-1:0] step_cnt_next;
  logic [IDX_W-1:0] idx_reg;
  logic [IDX_W-1:0] idx_next;
  logic [SCAN_PINS-1:0] oe_reg;
  logic [SCAN_PINS-1:0] oe_next;
  logic [STEP_W-1:0] step_last;
  logic step;

  // Pins are asynchronous to the core clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // Idle level of pulled-up pins, so no false edge after reset
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= ext_irq_pin_n; // RL23
      sync2_reg <= sync1_reg; // RL23
    end
  end

  tick_divider #(
    .DIV(LF_DIV)
  ) u_lf_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(lf_tick)
  );

  tick_divider #(
    .DIV(RC_DIV)
  ) u_rc_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(rc_tick)
  );

  // The clock is never truly gated here, so the asynchronous path is only
  // modelled: it keeps the synchroniser but bypasses filter and edge logic.
  generate
    for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
      line_detect u_det (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_sync(sync2_reg[i]),
        .sample_en(async_select[i] | ~stop_mode | lf_tick), // RL9 RL10
        .line_active(enabled_reg[i] & (async_select[i] | ~static_mode)), // RL11
        .sense_level(sense_type[i]),
        .edge_rise(edge_polarity[i]),
        .level_high(level_polarity[i]),
        .filter_on(filter_enable[i]),
        .async_on(async_select[i]),
        .trig(det_vec[i])
      );
    end
  endgenerate

  always_comb begin
    en_set = line_enable_strobe & ~line_disable_strobe;
    trig_vec = det_vec | (test_enable ? (test_trigger & enabled_reg) : '0);
    // Disable wins when both strobes hit the same bit
    enabled_next = (enabled_reg | en_set) & ~line_disable_strobe; // RL1
    mask_next = (mask_reg | irq_enable_strobe) & ~irq_disable_strobe; // RL2 RL19
    flags_next = (flags_reg & ~irq_clear_strobe) | trig_vec; // RL3
    req_next = flags_reg[NUM_EXT-1:0] & mask_reg[NUM_EXT-1:0]; // RL22 RL19
    nmi_next = flags_reg[NMI_BIT] & mask_reg[NMI_BIT]; // RL13 RL22
    wake_next = |trig_vec; // RL12
    wake_h_next = |(trig_vec & mask_reg); // RL12
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      enabled_reg <= LINE_RST; // RL14
      mask_reg <= LINE_RST;
      flags_reg <= LINE_RST;
      req_reg <= '0;
      nmi_reg <= 1'b0;
      wake_reg <= 1'b0;
      wake_h_reg <= 1'b0;
    end else begin
      enabled_reg <= enabled_next;
      mask_reg <= mask_next;
      flags_reg <= flags_next;
      req_reg <= req_next;
      nmi_reg <= nmi_next;
      wake_reg <= wake_next;
      wake_h_reg <= wake_h_next;
    end
  end

  assign req_any = (|req_reg) | nmi_reg;

  // Wide counter so the largest prescale still fits
  always_comb begin
    step_last = (STEP_ONE << (STEP_W'(scan_prescale) + STEP_ONE)) - STEP_ONE; // RL16 RL21
    step = scan_enable && !req_any && rc_tick && step_cnt_reg == step_last;
    step_cnt_next = step_cnt_reg;
    idx_next = idx_reg;
    if (!scan_enable) begin
      step_cnt_next = '0;
      idx_next = IDX_FIRST; // RL15
    end else if (!req_any && rc_tick) begin // RL17
      step_cnt_next = step ? '0 : step_cnt_reg + STEP_ONE;
      if (step) begin
        idx_next = (idx_reg == IDX_LAST) ? IDX_FIRST : idx_reg + IDX_W'(1); // RL16
      end
    end
    oe_next = scan_enable ? (SCAN_PINS'(1) << idx_next) : '0; // RL15
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      step_cnt_reg <= '0;
      idx_reg <= IDX_FIRST;
      oe_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_next;
      idx_reg <= idx_next;
      oe_reg <= oe_next;
    end
  end

  assign line_enabled = enabled_reg; // RL1
  assign irq_mask_view = mask_reg; // RL2
  assign irq_status_flags = flags_reg; // RL3
  assign irq_req = req_reg;
  assign nmi_req = nmi_reg;
  assign wake = wake_reg;
  assign wake_to_handler = wake_h_reg;
  assign scan_out = '0;
  assign scan_oe = oe_reg;
  assign scan_index = idx_reg; // RL20

  AST_ENABLE_SET: // RL1
  assert property (@(posedge ref_clk) disable iff (!rstn)
    en_set != '0 |=> (line_enabled & $past(en_set)) == $past(en_set))
    else $error("line enable strobe not applied");

  AST_MASK_CLEAR: // RL2
  assert property (@(posedge ref_clk) disable iff (!rstn)
    irq_disable_strobe != '0 |=> (irq_mask_view & $past(irq_disable_strobe)) == '0)
    else $error("irq disable strobe not applied");

  AST_FLAG_HOLD: // RL3
  assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> (($past(irq_status_flags) & ~$past(irq_clear_strobe)) & ~irq_status_flags) == '0)
    else $error("status flag dropped without clear");

  AST_SET_WINS: // RL3
  assert property (@(posedge ref_clk) disable iff (!rstn)
    trig_vec != '0 |=> (irq_status_flags & $past(trig_vec)) == $past(trig_vec))
    else $error("trigger lost");

  AST_REQ_FORM: // RL22
  assert property (@(posedge ref_clk) disable iff (!rstn)
    ##1 irq_req == $past(irq_status_flags[NUM_EXT-1:0] & irq_mask_view[NUM_EXT-1:0]))
    else $error("request not flag and mask");

  AST_NMI_REQ: // RL13
  assert property (@(posedge ref_clk) disable iff (!rstn)
    (irq_status_flags[NMI_BIT] && irq_mask_view[NMI_BIT]) |=> nmi_req)
    else $error("nmi request missing");

  AST_DISABLED_QUIET: // RL14
  assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> ((irq_status_flags & ~$past(irq_status_flags)) & ~$past(line_enabled)) == '0)
    else $error("disabled line flagged");

  AST_STATIC_ASYNC: // RL11
  assert property (@(posedge ref_clk) disable iff (!rstn)
    (static_mode && !test_enable) |=> ((irq_status_flags & ~$past(irq_status_flags)) & ~$past(async_select)) == '0)
    else $error("sync line flagged in static mode");

  AST_SCAN_HOLD: // RL17
  assert property (@(posedge ref_clk) disable iff (!rstn)
    (req_any && scan_enable) |=> scan_index == $past(scan_index))
    else $error("scan moved during request");

  AST_SCAN_WRAP: // RL16
  assert property (@(posedge ref_clk) disable iff (!rstn)
    (step && scan_index == IDX_LAST) |=> scan_index == IDX_FIRST)
    else $error("scan did not wrap");

  AST_SCAN_ONE_LOW: // RL15
  assert property (@(posedge ref_clk) disable iff (!rstn)
    scan_enable ##1 scan_enable |-> scan_oe == (SCAN_PINS'(1) << scan_index))
    else $error("scan drive pattern wrong");

  AST_LINE_OFF: // RL1
  assert property (@(posedge ref_clk) disable iff (!rstn)
    line_disable_strobe != '0 |=> (line_enabled & $past(line_disable_strobe)) == '0)
    else $error("line disable strobe not applied");

  AST_MASK_SET: // RL2
  assert property (@(posedge ref_clk) disable iff (!rstn)
    (irq_enable_strobe & ~irq_disable_strobe) != '0 |=>
      (irq_mask_view & $past(irq_enable_strobe)) == $past(irq_enable_strobe & ~irq_disable_strobe))
    else $error("irq enable strobe not applied");

  AST_WAKE_ANY: // RL12
  assert property (@(posedge ref_clk) disable iff (!rstn)
    trig_vec != '0 |=> wake)
    else $error("trigger did not wake");

  AST_WAKE_MASKED: // RL12
  assert property (@(posedge ref_clk) disable iff (!rstn)
    (trig_vec & irq_mask_view) == '0 |=> !wake_to_handler)
    else $error("handler wake without unmasked trigger");

  AST_NMI_OFF: // RL22
  assert property (@(posedge ref_clk) disable iff (!rstn)
    !(irq_status_flags[NMI_BIT] && irq_mask_view[NMI_BIT]) |=> !nmi_req)
    else $error("nmi request without flag and mask");

  AST_SCAN_STEP: // RL16
  assert property (@(posedge ref_clk) disable iff (!rstn)
    (step && scan_index != IDX_LAST) |=> scan_index == $past(scan_index) + IDX_W'(1))
    else $error("scan did not advance");

  AST_SCAN_OFF: // RL15
  assert property (@(posedge ref_clk) disable iff (!rstn)
    !scan_enable |=> (scan_oe == '0 && scan_index == IDX_FIRST))
    else $error("scan not idle while disabled");
endmodule : ext_irq_unit
`default_nettype wire

// *** verification/keypad_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module keypad_model (
  input wire logic [7:0] scan_oe,
  input wire logic [7:0] scan_out,
  input wire logic [8:0] pin_drive,
  input wire logic key_down,
  input wire logic [2:0] key_row,
  input wire logic [2:0] key_col,
  output logic [8:0] pin_level
);
  // Rows idle high by pull-up; a pressed key shorts its row to a driven column
  always_comb begin
    pin_level = pin_drive;
    if (key_down && scan_oe[key_col] && !scan_out[key_col]) begin
      pin_level[key_row] = 1'b0;
    end
  end
endmodule : keypad_model
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ext_irq_pkg::*;
  logic ref_clk, rstn, ten, stp, sta, sen, key, wk, wkh;
  logic [8:0] drv, pins, len, lds, ien, ids, icl, sns, edg, lvl, flt, asy, ttr, en_o, msk_o, flg_o;
  logic [7:0] req_o, oe_o, so_o;
  logic [4:0] psc;
  logic [2:0] krow, kcol, idx_o;
  logic nmi_o, wk_o, wkh_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  ext_irq_unit #(.LF_DIV(4), .RC_DIV(2)) i_ext_irq_unit (.ref_clk(ref_clk), .rstn(rstn),
    .ext_irq_pin_n(pins), .line_enable_strobe(len), .line_disable_strobe(lds),
    .irq_enable_strobe(ien), .irq_disable_strobe(ids), .irq_clear_strobe(icl),
    .sense_type(sns), .edge_polarity(edg), .level_polarity(lvl), .filter_enable(flt),
    .async_select(asy), .test_enable(ten), .test_trigger(ttr), .stop_mode(stp),
    .static_mode(sta), .scan_enable(sen), .scan_prescale(psc), .line_enabled(en_o),
    .irq_mask_view(msk_o), .irq_status_flags(flg_o), .irq_req(req_o), .nmi_req(nmi_o),
    .wake(wk_o), .wake_to_handler(wkh_o), .scan_out(so_o), .scan_oe(oe_o), .scan_index(idx_o));
  keypad_model i_keypad_model (.scan_oe(oe_o), .scan_out(so_o), .pin_drive(drv),
    .key_down(key), .key_row(krow), .key_col(kcol), .pin_level(pins));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Sticky capture, wake may be a single-cycle pulse
  always @(negedge ref_clk) begin
    if (wk_o === 1'b1) wk = 1'b1;
    if (wkh_o === 1'b1) wkh = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic strobe(input int k, input logic [8:0] b);
    case (k)
      0: len = b;
      1: lds = b;
      2: ien = b;
      3: ids = b;
      default: icl = b;
    endcase
    cyc(1);
    {len, lds, ien, ids, icl} = '0;
    cyc(1);
  endtask : strobe
  task automatic t_reset();
    chk("enabled", 9'h000, en_o);
    chk("mask", 9'h000, msk_o);
    chk("oe", 9'h000, {1'b0, oe_o});
    $display("test reset done");
  endtask : t_reset
  task automatic t_enable();
    strobe(0, 9'h1ff);
    chk("enabled", 9'h1ff, en_o);
    strobe(1, 9'h0aa);
    chk("enabled", 9'h155, en_o);
    strobe(2, 9'h00f);
    strobe(3, 9'h005);
    chk("mask", 9'h00a, msk_o);
    strobe(1, 9'h1ff);
    strobe(3, 9'h1ff);
    chk("enabled", 9'h000, en_o);
    $display("test enable done");
  endtask : t_enable
  task automatic t_edge();
    strobe(0, 9'h003);
    strobe(2, 9'h001);
    wk = 1'b0;
    wkh = 1'b0;
    drv = 9'h1fc;
    cyc(26);
    chk("flags", 9'h003, flg_o);
    chk("req", 9'h001, {1'b0, req_o});
    chk("wake", 9'h003, {7'h00, wk, wkh});
    strobe(4, 9'h001);
    chk("flags", 9'h002, flg_o);
    edg = 9'h002;
    strobe(4, 9'h002);
    drv = 9'h1ff;
    cyc(6);
    chk("flags", 9'h002, flg_o);
    strobe(4, 9'h003);
    strobe(1, 9'h003);
    strobe(3, 9'h1ff);
    edg = 9'h000;
    $display("test edge done");
  endtask : t_edge
  task automatic t_level();
    {wk, wkh} = '0;
    sns = 9'h002;
    lvl = 9'h002;
    strobe(0, 9'h002);
    cyc(6);
    strobe(4, 9'h002);
    chk("flags", 9'h002, flg_o);
    chk("wake", 9'h002, {7'h00, wk, wkh});
    lvl = 9'h000;
    cyc(6);
    strobe(4, 9'h002);
    cyc(2);
    chk("flags", 9'h000, flg_o);
    strobe(1, 9'h002);
    sns = 9'h000;
    $display("test level done");
  endtask : t_level
  task automatic t_filter();
    stp = 1'b1;
    flt = 9'h001;
    strobe(0, 9'h001);
    drv = 9'h1fe;
    cyc(4);
    drv = 9'h1ff;
    cyc(24);
    chk("flags", 9'h000, flg_o);
    drv = 9'h1fe;
    cyc(24);
    chk("flags", 9'h001, flg_o);
    drv = 9'h1ff;
    {stp, flt} = '0;
    strobe(1, 9'h001);
    strobe(4, 9'h001);
    $display("test filter done");
  endtask : t_filter
  task automatic t_static();
    sta = 1'b1;
    asy = 9'h010;
    edg = 9'h010;
    strobe(0, 9'h018);
    drv = 9'h1d7;
    cyc(8);
    chk("flags", 9'h010, flg_o);
    sta = 1'b0;
    strobe(1, 9'h018);
    {asy, edg} = '0;
    drv = 9'h1ff;
    strobe(4, 9'h1ff);
    $display("test static done");
  endtask : t_static
  task automatic t_nmi();
    ten = 1'b1;
    ttr = 9'h100;
    strobe(0, 9'h100);
    strobe(2, 9'h100);
    chk("flags", 9'h100, flg_o);
    chk("nmi", 9'h001, {8'h00, nmi_o});
    {ten, ttr} = '0;
    strobe(4, 9'h100);
    cyc(1);
    chk("nmi", 9'h000, {8'h00, nmi_o});
    strobe(1, 9'h100);
    strobe(3, 9'h100);
    $display("test nmi done");
  endtask : t_nmi
  task automatic t_scan();
    int i;
    int n;
    psc = 5'h01;
    sen = 1'b1;
    cyc(2);
    chk("oe", 9'h001, {1'b0, oe_o});
    chk("scan out", 9'h000, {1'b0, so_o});
    for (i = 0; i < 99 && idx_o === 3'h0; i++) cyc(1);
    for (n = 0; n < 99 && idx_o === 3'h1; n++) cyc(1);
    chk("period", 9'd8, n[8:0]);
    chk("oe", 9'h004, {1'b0, oe_o});
    for (i = 0; i < 99 && idx_o !== 3'h7; i++) cyc(1);
    for (i = 0; i < 99 && idx_o === 3'h7; i++) cyc(1);
    chk("wrap", 9'h001, {1'b0, oe_o});
    psc = 5'h03;
    sns = 9'h004;
    strobe(0, 9'h004);
    strobe(2, 9'h004);
    krow = 3'h2;
    kcol = 3'h5;
    key = 1'b1;
    for (i = 0; i < 900 && req_o[2] !== 1'b1; i++) cyc(1);
    chk("req", 9'h004, {1'b0, req_o});
    cyc(80);
    chk("index", 9'h005, {6'h00, idx_o});
    key = 1'b0;
    cyc(6);
    strobe(4, 9'h004);
    for (i = 0; i < 99 && idx_o === 3'h5; i++) cyc(1);
    chk("index", 9'h006, {6'h00, idx_o});
    sen = 1'b0;
    cyc(2);
    chk("oe", 9'h000, {1'b0, oe_o});
    $display("test scan done");
  endtask : t_scan
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #(200_000);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    drv = 9'h1ff;
    {len, lds, ien, ids, icl, sns, edg, lvl, flt, asy, ttr} = '0;
    {ten, stp, sta, sen, key, wk, wkh, psc, krow, kcol} = '0;
    cyc(16);
    rstn = 1'b1;
    t_reset();
    t_enable();
    t_edge();
    t_level();
    t_filter();
    t_static();
    t_nmi();
    t_scan();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
